/* servo_fault_code_reporter.sv */
// Fault detection, error code monitor and APB register file of the servo controller
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
module servo_fault_code_reporter
    import servo_fault_pkg::*;
#(
    parameter logic [31:0] BUS_TIMEOUT = 32'(BUS_TIMEOUT_CYCLES)
)
(
    // Clock, reset, enable
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CE,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Encoder conditions
    input  wire logic        ENC_CRC_FAIL,
    input  wire logic        ENC_POS_INVALID,
    input  wire logic        ENC_AMPL_LOW,
    input  wire logic        ENC_FREQ_HIGH,
    input  wire logic        ENC_FUSE_OPEN,
    // Motion and I/O
    input  wire logic [31:0] TRACKING_ERROR,
    input  wire logic [31:0] VELOCITY,
    input  wire logic        POWER_ON_REQ,
    input  wire logic [15:0] DIGITAL_INPUTS,
    input  wire logic        MOVE_ACTIVE,
    input  wire logic        INDEX_HOMING_CMD,
    input  wire logic        LIMIT_SEARCH_CMD,
    input  wire logic        LIMIT_SWITCH_HIT,
    // Sequencer
    input  wire logic        LABEL_DUPLICATE,
    input  wire logic        JUMP_STROBE,
    input  wire logic [15:0] JUMP_LABEL,
    input  wire logic        SEQ_EXEC,
    input  wire logic [15:0] SEQ_LINE,
    input  wire logic        REG_ACCESS,
    input  wire logic [15:0] REG_INDEX,
    input  wire logic [15:0] REG_INDEX_MAX,
    input  wire logic        CALL_PUSH,
    input  wire logic        CALL_POP,
    // Supervisory bus
    input  wire logic        BUS_CMD,
    input  wire logic        NODE_DUPLICATE,
    // Fault outputs
    output logic      [7:0]  ERROR_CODE,
    output logic             ERROR_HW_CLASS,
    output logic             BRAKE_ON,
    output logic             IRQ
);

    fault_state_t s;
    fault_state_t next_s;

    logic [NUM_EV-1:0] ev;
    logic              wr_en;
    logic              setup;
    logic              sw_reset;
    logic              temp_hot;
    logic [4:0]        pick;

    function automatic logic [31:0] magnitude(input logic [31:0] v);
        return v[31] ? 32'(-v) : v;
    endfunction

    function automatic logic [4:0] first_event(input logic [NUM_EV-1:0] e);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = NUM_EV - 1; i >= 0; i--)
        begin
            if (e[i])
                idx = 5'(i);
        end
        return idx;
    endfunction

    assign setup    = PSEL && !PENABLE;
    assign wr_en    = PSEL && PENABLE && PWRITE && s.pready;
    assign sw_reset = wr_en && (PADDR == OFS_CTRL) && PWDATA[CTRL_SW_RESET_BIT];
    assign temp_hot = s.temp_cfg[TEMP_ENABLE_BIT]
                      && DIGITAL_INPUTS[s.temp_cfg[TEMP_SEL_LSB +: 4]];
    assign pick     = first_event(ev);

    // Fault event detection
    always_comb
    begin
        ev     = '0;
        ev[0]  = ENC_CRC_FAIL;
        ev[1]  = ENC_POS_INVALID;
        ev[2]  = ENC_AMPL_LOW;
        ev[3]  = ENC_FREQ_HIGH;
        ev[4]  = magnitude(TRACKING_ERROR) > s.track_lim;
        ev[5]  = magnitude(VELOCITY) > s.vel_lim;
        ev[6]  = POWER_ON_REQ && !DIGITAL_INPUTS[0] && (s.pwr_chk == 8'h00);
        ev[7]  = temp_hot;
        ev[8]  = s.lim_cfg[LIM_CFG_ENABLE_BIT] && MOVE_ACTIVE && LIMIT_SWITCH_HIT
                 && !INDEX_HOMING_CMD && !LIMIT_SEARCH_CMD;
        ev[9]  = LABEL_DUPLICATE;
        ev[10] = ENC_FUSE_OPEN;
        ev[11] = JUMP_STROBE && (JUMP_LABEL > LABEL_MAX);
        ev[12] = SEQ_EXEC && (SEQ_LINE > LINE_MAX);
        ev[13] = REG_ACCESS && (REG_INDEX > REG_INDEX_MAX);
        ev[14] = CALL_PUSH && !CALL_POP && (s.depth == STACK_DEPTH);
        ev[15] = s.cfg_a > CFG_A_MAX;
        ev[16] = s.cfg_b > CFG_B_MAX;
        ev[17] = s.temp_cfg[TEMP_BUS_WD_BIT] && !BUS_CMD
                 && (s.bus_cnt >= s.bus_to);
        ev[18] = NODE_DUPLICATE;
    end

    // Next-state logic
    always_comb
    begin
        next_s = s;

        // APB: ready one cycle after setup, cleared after the access
        next_s.pready  = 1'b0;
        next_s.pslverr = 1'b0;
        if (setup)
        begin
            next_s.pready = 1'b1;
            next_s.prdata = 32'h0000_0000;
            unique case (PADDR)
                OFS_CTRL:      next_s.prdata = 32'h0000_0000;
                OFS_MONITOR:   next_s.prdata = {22'h00_0000, s.brake, s.hw_class, s.code};
                OFS_STATUS:    next_s.prdata = {13'h0000, s.status};
                OFS_MASK:      next_s.prdata = {13'h0000, s.mask};
                OFS_TRACK_LIM: next_s.prdata = s.track_lim;
                OFS_VEL_LIM:   next_s.prdata = s.vel_lim;
                OFS_LIM_CFG:   next_s.prdata = {24'h00_0000, s.lim_cfg};
                OFS_PWR_CHK:   next_s.prdata = {24'h00_0000, s.pwr_chk};
                OFS_TEMP_CFG:  next_s.prdata = {24'h00_0000, s.temp_cfg};
                OFS_CFG_A:     next_s.prdata = {16'h0000, s.cfg_a};
                OFS_CFG_B:     next_s.prdata = {16'h0000, s.cfg_b};
                OFS_BUS_TO:    next_s.prdata = s.bus_to;
                OFS_DEPTH:     next_s.prdata = {23'h00_0000, s.depth};
                default:       next_s.pslverr = 1'b1;
            endcase
        end

        // Register writes
        if (wr_en)
        begin
            unique case (PADDR)
                OFS_STATUS:    next_s.status    = s.status & ~PWDATA[NUM_EV-1:0];
                OFS_MASK:      next_s.mask      = PWDATA[NUM_EV-1:0];
                OFS_TRACK_LIM: next_s.track_lim = PWDATA;
                OFS_VEL_LIM:   next_s.vel_lim   = PWDATA;
                OFS_LIM_CFG:   next_s.lim_cfg   = PWDATA[7:0];
                OFS_PWR_CHK:   next_s.pwr_chk   = PWDATA[7:0];
                OFS_TEMP_CFG:  next_s.temp_cfg  = PWDATA[7:0];
                OFS_CFG_A:     next_s.cfg_a     = PWDATA[15:0];
                OFS_CFG_B:     next_s.cfg_b     = PWDATA[15:0];
                OFS_BUS_TO:    next_s.bus_to    = PWDATA;
                default:       next_s.status    = s.status;
            endcase
        end

        // Sticky status: a new event wins over a write-one clear
        next_s.status = next_s.status | ev;

        // Call stack depth tracking
        if (CALL_PUSH && !CALL_POP && (s.depth != STACK_DEPTH))
            next_s.depth = s.depth + 9'h001;
        else if (CALL_POP && !CALL_PUSH && (s.depth != 9'h000))
            next_s.depth = s.depth - 9'h001;

        // Supervisory bus silence counter, restarted by each command
        if (BUS_CMD || !s.temp_cfg[TEMP_BUS_WD_BIT] || sw_reset)
            next_s.bus_cnt = 32'h0000_0000;
        else if (s.bus_cnt != 32'hFFFF_FFFF)
            next_s.bus_cnt = s.bus_cnt + 32'h0000_0001;

        // Software reset clears only software-class codes
        if (sw_reset && !s.hw_class)
        begin
            next_s.code  = 8'h00;
            next_s.brake = 1'b0;
        end

        // Latch the highest-priority event into an empty monitor
        if ((next_s.code == 8'h00) && (ev != '0))
        begin
            next_s.code     = EVENT_CODE[pick];
            next_s.hw_class = EVENT_HW[pick];
            next_s.brake    = EVENT_BRAKE[pick];
        end
        else if (next_s.code == 8'h00)
        begin
            next_s.hw_class = 1'b0;
        end

        next_s.irq = |(next_s.status & next_s.mask);
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            s           <= '0;
            s.track_lim <= TRACK_LIM_RST;
            s.vel_lim   <= VEL_LIM_RST;
            s.lim_cfg   <= LIM_CFG_RST;
            s.pwr_chk   <= PWR_CHK_RST;
            s.temp_cfg  <= TEMP_CFG_RST;
            s.cfg_a     <= CFG_A_RST;
            s.cfg_b     <= CFG_B_RST;
            s.bus_to    <= BUS_TIMEOUT;
        end
        else if (CE)
        begin
            s <= next_s;
        end
    end

    assign PRDATA         = s.prdata;
    assign PREADY         = s.pready;
    assign PSLVERR        = s.pslverr;
    assign ERROR_CODE     = s.code;
    assign ERROR_HW_CLASS = s.hw_class;
    assign BRAKE_ON       = s.brake;
    assign IRQ            = s.irq;

    AST_CRC_CODE: assert property (@(posedge CLK) disable iff (RST)
        (CE && s.code == 8'h00 && ENC_CRC_FAIL)
        |=> (ERROR_CODE == ERR_ENC_CRC) && ERROR_HW_CLASS && BRAKE_ON)
        else $error("checksum failure did not raise code 18");

    AST_TRACK_SET: assert property (@(posedge CLK) disable iff (RST)
        (CE && magnitude(TRACKING_ERROR) > s.track_lim) |=> s.status[4])
        else $error("tracking error not flagged");

    AST_SPEED_SET: assert property (@(posedge CLK) disable iff (RST)
        (CE && magnitude(VELOCITY) > s.vel_lim) |=> s.status[5])
        else $error("overspeed not flagged");

    AST_PWR_IN: assert property (@(posedge CLK) disable iff (RST)
        (CE && POWER_ON_REQ && !DIGITAL_INPUTS[0] && s.pwr_chk == 8'h00 && s.code == 8'h00
         && ev[5:0] == 6'h00)
        |=> ERROR_CODE == ERR_PWR_IN && !ERROR_HW_CLASS)
        else $error("power-on input check did not raise code 26");

    AST_LIMIT_HOMING: assert property (@(posedge CLK) disable iff (RST)
        (CE && !s.status[8] && (INDEX_HOMING_CMD || LIMIT_SEARCH_CMD)
         && !(wr_en && PADDR == OFS_STATUS))
        |=> !s.status[8])
        else $error("limit switch flagged during homing or search");

    AST_LABEL_RANGE: assert property (@(posedge CLK) disable iff (RST)
        (CE && JUMP_STROBE && JUMP_LABEL > LABEL_MAX) |=> s.status[11])
        else $error("jump label above 511 not flagged");

    AST_LINE_RANGE: assert property (@(posedge CLK) disable iff (RST)
        (CE && SEQ_EXEC && SEQ_LINE == LINE_MAX && !s.status[12]
         && !(wr_en && PADDR == OFS_STATUS))
        |=> !s.status[12])
        else $error("line 8190 wrongly flagged");

    AST_STACK_OVF: assert property (@(posedge CLK) disable iff (RST)
        (CE && CALL_PUSH && !CALL_POP && s.depth == STACK_DEPTH)
        |=> s.status[14] && s.depth == STACK_DEPTH)
        else $error("stack overflow not flagged");

    AST_BUS_SILENCE: assert property (@(posedge CLK) disable iff (RST)
        (CE && s.temp_cfg[TEMP_BUS_WD_BIT] && !BUS_CMD && s.bus_cnt >= s.bus_to)
        |=> s.status[17])
        else $error("supervisory bus silence not flagged");

    AST_HW_HOLD: assert property (@(posedge CLK) disable iff (RST)
        (s.hw_class && s.code != 8'h00) |=> $stable(ERROR_CODE) && ERROR_HW_CLASS)
        else $error("hardware-class code changed without hardware reset");

    AST_SW_CLEAR: assert property (@(posedge CLK) disable iff (RST)
        (CE && sw_reset && !s.hw_class && ev == '0) |=> ERROR_CODE == 8'h00 && !BRAKE_ON)
        else $error("software reset did not clear software-class code");

    AST_IRQ_LEVEL: assert property (@(posedge CLK) disable iff (RST)
        IRQ == |(s.status & s.mask))
        else $error("interrupt does not follow masked status");

endmodule

/* servo_fault_pkg.sv */
// Constants, register map, event table and state type of the servo fault reporter
// How it works
// - Encoder link checksum failure: code 18, hardware-cleared, brake on
// - Invalid absolute position: code 19, hardware-cleared, brake on
// - Encoder amplitude too low: code 20, hardware-cleared
// - Encoder frequency too high: code 21, hardware-cleared
// - Tracking error above limit: code 23, software-cleared
// - Velocity above limit: code 24, software-cleared
// - Power-on with input one low, check zero: 26
// - Selected temperature input overheat: code 29, brake off
// - Limit switch in ordinary move, enabled: code 30
// - Duplicate sequence label: code 33, software-cleared
// - Encoder supply fuse open: code 35, brake off
// - Jump or call label above 511: code 36
// - Sequence line above 8190: code 37
// - Register index beyond group maximum: code 38
// - Call stack overflow past 256: code 39, hardware
// - Bad validated parameters: codes 40, 41, hardware
// - Supervisory bus silence, when enabled: code 56
// - Duplicate node numbers on supervisory bus: code 59
package servo_fault_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_MONITOR   = 8'h04;
    localparam logic [7:0] OFS_STATUS    = 8'h08;
    localparam logic [7:0] OFS_MASK      = 8'h0C;
    localparam logic [7:0] OFS_TRACK_LIM = 8'h10;
    localparam logic [7:0] OFS_VEL_LIM   = 8'h14;
    localparam logic [7:0] OFS_LIM_CFG   = 8'h18;
    localparam logic [7:0] OFS_PWR_CHK   = 8'h1C;
    localparam logic [7:0] OFS_TEMP_CFG  = 8'h20;
    localparam logic [7:0] OFS_CFG_A     = 8'h24;
    localparam logic [7:0] OFS_CFG_B     = 8'h28;
    localparam logic [7:0] OFS_BUS_TO    = 8'h2C;
    localparam logic [7:0] OFS_DEPTH     = 8'h30;

    // Field positions
    localparam int CTRL_SW_RESET_BIT  = 0;
    localparam int LIM_CFG_ENABLE_BIT = 0;
    localparam int TEMP_ENABLE_BIT    = 0;
    localparam int TEMP_BUS_WD_BIT    = 1;
    localparam int TEMP_SEL_LSB       = 4;
    localparam int MON_HW_BIT         = 8;
    localparam int MON_BRAKE_BIT      = 9;

    // Reset values
    localparam logic [31:0] TRACK_LIM_RST = 32'h0000_1000;
    localparam logic [31:0] VEL_LIM_RST   = 32'h0001_0000;
    localparam logic [7:0]  LIM_CFG_RST   = 8'h00;
    localparam logic [7:0]  PWR_CHK_RST   = 8'h01;
    localparam logic [7:0]  TEMP_CFG_RST  = 8'h00;
    localparam logic [15:0] CFG_A_RST     = 16'h0000;
    localparam logic [15:0] CFG_B_RST     = 16'h0000;

    // Largest legal values
    localparam logic [15:0] CFG_A_MAX     = 16'h0003;
    localparam logic [15:0] CFG_B_MAX     = 16'h0003;
    localparam logic [15:0] LABEL_MAX     = 16'h01FF;
    localparam logic [15:0] LINE_MAX      = 16'h1FFE;
    localparam logic [8:0]  STACK_DEPTH   = 9'h100;

    // Supervisory bus silence time
    localparam int BUS_TIMEOUT_US     = 1000;
    localparam int CLK_MHZ            = 200;
    localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_US * CLK_MHZ;

    // Error codes
    localparam int NUM_EV = 19;
    localparam logic [7:0] ERR_ENC_CRC   = 8'h12;
    localparam logic [7:0] ERR_ENC_POS   = 8'h13;
    localparam logic [7:0] ERR_ENC_AMPL  = 8'h14;
    localparam logic [7:0] ERR_ENC_FREQ  = 8'h15;
    localparam logic [7:0] ERR_TRACK     = 8'h17;
    localparam logic [7:0] ERR_SPEED     = 8'h18;
    localparam logic [7:0] ERR_PWR_IN    = 8'h1A;
    localparam logic [7:0] ERR_OVERTEMP  = 8'h1D;
    localparam logic [7:0] ERR_LIMIT     = 8'h1E;
    localparam logic [7:0] ERR_MULT_LAB  = 8'h21;
    localparam logic [7:0] ERR_FUSE      = 8'h23;
    localparam logic [7:0] ERR_LABEL     = 8'h24;
    localparam logic [7:0] ERR_SEQ_LINE  = 8'h25;
    localparam logic [7:0] ERR_REG_NUM   = 8'h26;
    localparam logic [7:0] ERR_STACK     = 8'h27;
    localparam logic [7:0] ERR_CFG_A     = 8'h28;
    localparam logic [7:0] ERR_CFG_B     = 8'h29;
    localparam logic [7:0] ERR_BUS_WD    = 8'h38;
    localparam logic [7:0] ERR_NODE_DUP  = 8'h3B;

    // Event index order: bit 0 has highest priority
    localparam logic [NUM_EV-1:0][7:0] EVENT_CODE = {
        ERR_NODE_DUP, ERR_BUS_WD, ERR_CFG_B, ERR_CFG_A, ERR_STACK,
        ERR_REG_NUM, ERR_SEQ_LINE, ERR_LABEL, ERR_FUSE, ERR_MULT_LAB,
        ERR_LIMIT, ERR_OVERTEMP, ERR_PWR_IN, ERR_SPEED, ERR_TRACK,
        ERR_ENC_FREQ, ERR_ENC_AMPL, ERR_ENC_POS, ERR_ENC_CRC};
    localparam logic [NUM_EV-1:0] EVENT_HW    = 19'h1_C00F;
    localparam logic [NUM_EV-1:0] EVENT_BRAKE = 19'h7_FB7F;

    typedef struct packed {
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
        logic              irq;
        logic [7:0]        code;
        logic              hw_class;
        logic              brake;
        logic [NUM_EV-1:0] status;
        logic [NUM_EV-1:0] mask;
        logic [31:0]       track_lim;
        logic [31:0]       vel_lim;
        logic [7:0]        lim_cfg;
        logic [7:0]        pwr_chk;
        logic [7:0]        temp_cfg;
        logic [15:0]       cfg_a;
        logic [15:0]       cfg_b;
        logic [31:0]       bus_to;
        logic [31:0]       bus_cnt;
        logic [8:0]        depth;
    } fault_state_t;

endpackage

/* servo_fault_host.sv */
// APB host model that programs, reads and resets the fault reporter
`timescale 1ns/1ps
module servo_fault_host
(
    // Clock
    input  wire logic        clk,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // Request held until pready is seen high at a rising edge, only then released
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err, output logic ok);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No wait limit here: only the bench watchdog ends a stuck access
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        ok  = (pready === 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released lines carry the inverse so stale values never pass for live ones
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule

/* testbench.sv */
// Self-checking bench for the servo fault code reporter
`timescale 1ns/1ps
module testbench
    import servo_fault_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, ce = 1'b1;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, err_code;
    logic [31:0] pwdata, prdata, rd;
    logic        enc_crc = '0, enc_pos = '0, enc_ampl = '0, enc_freq = '0, enc_fuse = '0;
    logic        pwr_req = '0, move = '0, homing = '0, search = '0, limit_hit = '0;
    logic        lab_dup = '0, jump = '0, seq_exec = '0, reg_acc = '0, push = '0, pop = '0;
    logic        bus_cmd = '0, node_dup = '0, hw_cls, brake, irq, er, ok;
    logic [31:0] track_err = '0, velocity = '0;
    logic [15:0] din = '0, jump_label = '0, seq_line = '0, reg_idx = '0, reg_max = '0;
    int          bad_count = 0;
    int          check_count = 0;
    // Codes 18..59 of the event order, reset class and brake per event
    localparam logic [7:0] CODES [19] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h17, 8'h18, 8'h1A,
        8'h1D, 8'h1E, 8'h21, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h38, 8'h3B};
    localparam logic [18:0] HW_SET    = 19'h1_C00F;
    localparam logic [18:0] BRAKE_SET = 19'h7_FB7F;

    servo_fault_code_reporter #(.BUS_TIMEOUT(32'h0000_0014)) dut (
        .CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .ENC_CRC_FAIL(enc_crc), .ENC_POS_INVALID(enc_pos), .ENC_AMPL_LOW(enc_ampl),
        .ENC_FREQ_HIGH(enc_freq), .ENC_FUSE_OPEN(enc_fuse), .TRACKING_ERROR(track_err),
        .VELOCITY(velocity), .POWER_ON_REQ(pwr_req), .DIGITAL_INPUTS(din), .MOVE_ACTIVE(move),
        .INDEX_HOMING_CMD(homing), .LIMIT_SEARCH_CMD(search), .LIMIT_SWITCH_HIT(limit_hit),
        .LABEL_DUPLICATE(lab_dup), .JUMP_STROBE(jump), .JUMP_LABEL(jump_label),
        .SEQ_EXEC(seq_exec), .SEQ_LINE(seq_line), .REG_ACCESS(reg_acc), .REG_INDEX(reg_idx),
        .REG_INDEX_MAX(reg_max), .CALL_PUSH(push), .CALL_POP(pop), .BUS_CMD(bus_cmd),
        .NODE_DUPLICATE(node_dup), .ERROR_CODE(err_code), .ERROR_HW_CLASS(hw_cls),
        .BRAKE_ON(brake), .IRQ(irq));

    servo_fault_host host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    always #2.5 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, er, ok);
        check({31'h0, ok}, 32'h1, "write answer");
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic e, input string w);
        host.xfer(1'b0, a, 32'h0000_0000, rd, er, ok);
        check(rd, exp, w);
        check({31'h0, er}, {31'h0, e}, "slave error");
    endtask

    task automatic do_reset();
        // Align to a rising edge, callers may end a step off the edge
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask

    task automatic quiet();
        {enc_crc, enc_pos, enc_ampl, enc_freq, enc_fuse, pwr_req, move, homing, search} <= '0;
        {limit_hit, lab_dup, jump, seq_exec, reg_acc, push, bus_cmd, node_dup} <= '0;
        {track_err, velocity, din} <= '0;
    endtask

    task automatic fire(input int i);
        if (i == 6) wr(OFS_PWR_CHK, 32'h0000_0000);
        if (i == 7) wr(OFS_TEMP_CFG, 32'h0000_0031);
        if (i == 8) wr(OFS_LIM_CFG, 32'h0000_0001);
        if (i == 15) wr(OFS_CFG_A, 32'h0000_0004);
        if (i == 16) wr(OFS_CFG_B, 32'h0000_0004);
        if (i == 17) wr(OFS_TEMP_CFG, 32'h0000_0002);
        @(posedge clk);
        case (i)
            0: enc_crc <= 1'b1;
            1: enc_pos <= 1'b1;
            2: enc_ampl <= 1'b1;
            3: enc_freq <= 1'b1;
            4: track_err <= 32'hFFFF_EFFF;
            5: velocity <= 32'h0001_0001;
            6: pwr_req <= 1'b1;
            7: din <= 16'h0008;
            8: {move, limit_hit} <= 2'b11;
            9: lab_dup <= 1'b1;
            10: enc_fuse <= 1'b1;
            11: {jump, jump_label} <= {1'b1, 16'h0200};
            12: {seq_exec, seq_line} <= {1'b1, 16'h1FFF};
            13: {reg_acc, reg_idx, reg_max} <= {1'b1, 16'h000B, 16'h000A};
            14: push <= 1'b1;
            18: node_dup <= 1'b1;
            default: ;
        endcase
        @(posedge clk);
        quiet();
    endtask

    task automatic run_event(input int i);
        int n;
        do_reset();
        if (i == 14)
        begin
            push <= 1'b1;
            repeat (256) @(posedge clk);
            push <= 1'b0;
            @(posedge clk);
            #1 check({24'h0, err_code}, 32'h0, "stack full");
            rd_chk(OFS_DEPTH, {23'h0, STACK_DEPTH}, 1'b0, "depth");
        end
        fire(i);
        for (n = 0; n < 64 && err_code === 8'h00; n++)
            @(posedge clk);
        #1 check({24'h0, err_code}, {24'h0, CODES[i]}, "code");
        check({31'h0, hw_cls}, {31'h0, HW_SET[i]}, "class");
        check({31'h0, brake}, {31'h0, BRAKE_SET[i]}, "brake");
        rd_chk(OFS_STATUS, 32'h0000_0001 << i, 1'b0, "status");
        rd_chk(OFS_MONITOR, {22'h0, BRAKE_SET[i], HW_SET[i], CODES[i]}, 1'b0, "monitor");
        if (i == 17) wr(OFS_TEMP_CFG, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0001);
        repeat (2) @(posedge clk);
        #1 check({24'h0, err_code}, HW_SET[i] ? {24'h0, CODES[i]} : 32'h0, "swr");
    endtask

    task automatic irq_case();
        do_reset();
        wr(OFS_MASK, 32'h0000_0001);
        fire(4);
        repeat (2) @(posedge clk);
        #1 check({31'h0, irq}, 32'h0, "masked irq");
        fire(0);
        repeat (2) @(posedge clk);
        #1 check({31'h0, irq}, 32'h1, "irq");
        check({24'h0, err_code}, 32'h0000_0017, "first held");
        wr(OFS_STATUS, 32'h0000_0001);
        @(posedge clk);
        #1 check({31'h0, irq}, 32'h0, "irq cleared");
        rd_chk(OFS_STATUS, 32'h0000_0010, 1'b0, "status after clear");
        // Clock enable low: a fault seen only while frozen must leave no trace
        do_reset();
        ce <= 1'b0;
        fire(0);
        @(posedge clk);
        ce <= 1'b1;
        #1 check({24'h0, err_code}, 32'h0, "frozen");
        rd_chk(OFS_STATUS, 32'h0000_0000, 1'b0, "frozen status");
    endtask

    task automatic edges_case();
        do_reset();
        rd_chk(OFS_TRACK_LIM, 32'h0000_1000, 1'b0, "track limit");
        rd_chk(OFS_VEL_LIM, 32'h0001_0000, 1'b0, "velocity limit");
        rd_chk(OFS_PWR_CHK, 32'h0000_0001, 1'b0, "power check");
        rd_chk(8'h40, 32'h0000_0000, 1'b1, "unmapped");
        wr(OFS_LIM_CFG, 32'h0000_0001);
        wr(OFS_TEMP_CFG, 32'h0000_0002);
        @(posedge clk);
        {jump, jump_label} <= {1'b1, 16'h01FF};
        {seq_exec, seq_line} <= {1'b1, 16'h1FFE};
        {reg_acc, reg_idx, reg_max} <= {1'b1, 16'h000A, 16'h000A};
        {track_err, velocity} <= {32'h0000_1000, 32'hFFFF_0000};
        {move, homing, limit_hit, pwr_req} <= 4'b1111;
        @(posedge clk);
        {homing, search, jump, seq_exec, reg_acc} <= 5'b01000;
        @(posedge clk);
        quiet();
        repeat (6)
        begin
            bus_cmd <= 1'b1;
            @(posedge clk);
            bus_cmd <= 1'b0;
            repeat (9) @(posedge clk);
        end
        #1 check({24'h0, err_code}, 32'h0, "no fault");
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        #100000;
        bad_count++;
        close_out();
    end

    initial
    begin
        edges_case();
        for (int i = 0; i < 4; i++) run_event(i);
        for (int i = 4; i < 14; i++) run_event(i);
        run_event(14);
        for (int i = 15; i < 17; i++) run_event(i);
        for (int i = 17; i < 19; i++) run_event(i);
        irq_case();
        close_out();
    end
endmodule
